// >>> verilog/pcd_pkg.sv
// constants and state types for the pin edge change detector
package pcd_pkg;

    localparam int          PCD_ADDR_W        = 4;
    localparam int          PCD_DATA_W        = 8;
    localparam int          PCD_VLD_W         = 3;

    // register offsets
    localparam logic [3:0]  PCD_OFF_B_RISE    = 4'h0;
    localparam logic [3:0]  PCD_OFF_B_FALL    = 4'h1;
    localparam logic [3:0]  PCD_OFF_B_FLAGS   = 4'h2;
    localparam logic [3:0]  PCD_OFF_C_RISE    = 4'h3;
    localparam logic [3:0]  PCD_OFF_C_FALL    = 4'h4;
    localparam logic [3:0]  PCD_OFF_C_FLAGS   = 4'h5;
    localparam logic [3:0]  PCD_OFF_CTRL      = 4'h6;
    localparam logic [3:0]  PCD_OFF_EVT_STAT  = 4'h7;
    localparam logic [3:0]  PCD_OFF_EVT_MASK  = 4'h8;

    // field positions
    localparam int          PCD_CTRL_IRQ_EN   = 0;
    localparam int          PCD_EVT_B         = 0;
    localparam int          PCD_EVT_C         = 1;
    localparam int          PCD_EVT_W         = 2;

    // reset values and implemented-bit masks
    localparam logic [7:0]  PCD_REG_RST       = 8'h00;
    localparam logic [7:0]  PCD_B_IMPL        = 8'hf0;
    localparam logic [7:0]  PCD_NONE_IMPL     = 8'h00;
    localparam logic [7:0]  PCD_C_IMPL_LARGE  = 8'hff;
    localparam logic [7:0]  PCD_C_IMPL_SMALL  = 8'h3f;
    localparam logic [1:0]  PCD_EVT_RST       = 2'h0;

    typedef struct packed {
        logic [7:0] b_rise;
        logic [7:0] b_fall;
        logic [7:0] c_rise;
        logic [7:0] c_fall;
        logic       irq_en;
        logic [1:0] evt_status;
        logic [1:0] evt_mask;
        logic [7:0] rd_data;
        logic       summary;
        logic       change_irq;
        logic       wake;
        logic       irq;
    } pcd_main_st_t;

endpackage

// >>> verilog/pcd_edge_detect.sv
// pin synchroniser and edge detector for one port
module pcd_edge_detect
    import pcd_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    typedef struct packed {
        logic [WIDTH-1:0]     s1;
        logic [WIDTH-1:0]     s2;
        logic [WIDTH-1:0]     prev;
        logic [PCD_VLD_W-1:0] vld;
    } pcd_edge_st_t;

    pcd_edge_st_t st_reg;
    pcd_edge_st_t st_next;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("pcd_edge_detect: WIDTH must be at least 1");
    end

    always_comb
    begin
        st_next = st_reg;
        if (clk_en)
        begin
            st_next.s1   = pins;
            st_next.s2   = st_reg.s1;
            st_next.prev = st_reg.s2;
            st_next.vld  = {st_reg.vld[PCD_VLD_W-2:0], 1'b1};
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // no edge is reported until prev holds a real sample, so a pin high at reset is not a rise
    assign rise = st_reg.vld[PCD_VLD_W-1] ? (st_reg.s2 & ~st_reg.prev) : '0;
    assign fall = st_reg.vld[PCD_VLD_W-1] ? (~st_reg.s2 & st_reg.prev) : '0;

    chk_edge_from_samples: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(clk_en) && st_reg.vld[PCD_VLD_W-1] |-> rise == ($past(st_reg.s1) & ~$past(st_reg.s2)))
        else $error("rise does not follow the last two synchronised samples");

endmodule

// >>> verilog/pcd_flag_bank.sv
// sticky per-pin change flags, hardware set, software clear by writing zero
module pcd_flag_bank
    import pcd_pkg::*;
#(
    parameter int         WIDTH = 8,
    parameter logic [7:0] IMPL  = 8'hff
)
(
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic             clr_wr,
    input  wire logic [WIDTH-1:0] clr_data,
    output logic      [WIDTH-1:0] flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } pcd_flag_st_t;

    pcd_flag_st_t st_reg;
    pcd_flag_st_t st_next;

    if (WIDTH != PCD_DATA_W)
    begin : g_bad_width
        $error("pcd_flag_bank: WIDTH must equal the register width");
    end

    always_comb
    begin
        st_next = st_reg;
        if (clk_en)
        begin
            // a write of one keeps a flag, never sets it; a detected edge wins over the clear
            if (clr_wr)
                st_next.flags = st_reg.flags & clr_data;
            st_next.flags = (st_next.flags | set_vec) & IMPL[WIDTH-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign flags = st_reg.flags;

    chk_unimpl_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_reg.flags & ~IMPL[WIDTH-1:0]) == '0)
        else $error("unimplemented flag bit is set");

    chk_set_wins: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && clr_wr && ((set_vec & IMPL[WIDTH-1:0]) != '0)
        |=> (st_reg.flags & $past(set_vec) & IMPL[WIDTH-1:0]) == ($past(set_vec) & IMPL[WIDTH-1:0]))
        else $error("edge during a clearing write was lost");

endmodule

// >>> verilog/pcd_detector.sv
// pin edge change detector top: enables, flags, summary, wake and event interrupt
module pcd_detector
    import pcd_pkg::*;
#(
    parameter int LARGE_VARIANT = 1
)
(
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic                  clk_en,
    input  wire logic [7:0]            port_b_pin,
    input  wire logic [7:0]            port_c_pin,
    input  wire logic                  sleep_mode,
    input  wire logic [PCD_ADDR_W-1:0] reg_addr,
    input  wire logic [PCD_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [PCD_DATA_W-1:0] reg_rdata,
    output logic                       change_summary_flag,
    output logic                       change_irq_request,
    output logic                       wake_request,
    output logic                       irq
);

    localparam logic [7:0] B_IMPL = (LARGE_VARIANT != 0) ? PCD_B_IMPL : PCD_NONE_IMPL;
    localparam logic [7:0] C_IMPL = (LARGE_VARIANT != 0) ? PCD_C_IMPL_LARGE : PCD_C_IMPL_SMALL;

    if (LARGE_VARIANT != 0 && LARGE_VARIANT != 1)
    begin : g_bad_variant
        $error("pcd_detector: LARGE_VARIANT must be 0 or 1");
    end

    function automatic logic hit(input logic [PCD_ADDR_W-1:0] addr, input logic [3:0] off);
        hit = (addr == off);
    endfunction

    pcd_main_st_t    st_reg;
    pcd_main_st_t    st_next;

    logic [7:0]      b_rise_hit;
    logic [7:0]      b_fall_hit;
    logic [7:0]      c_rise_hit;
    logic [7:0]      c_fall_hit;
    logic [7:0]      b_set;
    logic [7:0]      c_set;
    logic [7:0]      b_flags;
    logic [7:0]      c_flags;
    logic            b_flags_wr;
    logic            c_flags_wr;

    pcd_edge_detect #(
        .WIDTH (8)
    ) u_edge_b (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .pins    (port_b_pin),
        .rise    (b_rise_hit),
        .fall    (b_fall_hit)
    );

    pcd_edge_detect #(
        .WIDTH (8)
    ) u_edge_c (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .pins    (port_c_pin),
        .rise    (c_rise_hit),
        .fall    (c_fall_hit)
    );

    // detection does not look at the interrupt enable; only the request does
    assign b_set = ((b_rise_hit & st_reg.b_rise) | (b_fall_hit & st_reg.b_fall)) & B_IMPL;
    assign c_set = ((c_rise_hit & st_reg.c_rise) | (c_fall_hit & st_reg.c_fall)) & C_IMPL;

    assign b_flags_wr = reg_wr && hit(reg_addr, PCD_OFF_B_FLAGS);
    assign c_flags_wr = reg_wr && hit(reg_addr, PCD_OFF_C_FLAGS);

    pcd_flag_bank #(
        .WIDTH (8),
        .IMPL  (B_IMPL)
    ) u_flags_b (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .set_vec  (b_set),
        .clr_wr   (b_flags_wr),
        .clr_data (reg_wdata),
        .flags    (b_flags)
    );

    pcd_flag_bank #(
        .WIDTH (8),
        .IMPL  (C_IMPL)
    ) u_flags_c (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .set_vec  (c_set),
        .clr_wr   (c_flags_wr),
        .clr_data (reg_wdata),
        .flags    (c_flags)
    );

    logic [7:0] b_flags_next;
    logic [7:0] c_flags_next;
    logic [1:0] evt_raise;

    // the flag banks' next values, mirrored so summary outputs line up with the flag registers
    always_comb
    begin
        b_flags_next = b_flags;
        c_flags_next = c_flags;
        if (b_flags_wr)
            b_flags_next = b_flags & reg_wdata;
        if (c_flags_wr)
            c_flags_next = c_flags & reg_wdata;
        b_flags_next = (b_flags_next | b_set) & B_IMPL;
        c_flags_next = (c_flags_next | c_set) & C_IMPL;
    end

    assign evt_raise = {(c_set != 8'h00), (b_set != 8'h00)};

    always_comb
    begin
        st_next = st_reg;
        if (clk_en)
        begin
            if (reg_wr)
            begin
                if (hit(reg_addr, PCD_OFF_B_RISE))
                    st_next.b_rise = reg_wdata & B_IMPL;
                if (hit(reg_addr, PCD_OFF_B_FALL))
                    st_next.b_fall = reg_wdata & B_IMPL;
                if (hit(reg_addr, PCD_OFF_C_RISE))
                    st_next.c_rise = reg_wdata & C_IMPL;
                if (hit(reg_addr, PCD_OFF_C_FALL))
                    st_next.c_fall = reg_wdata & C_IMPL;
                if (hit(reg_addr, PCD_OFF_CTRL))
                    st_next.irq_en = reg_wdata[PCD_CTRL_IRQ_EN];
                if (hit(reg_addr, PCD_OFF_EVT_MASK))
                    st_next.evt_mask = reg_wdata[PCD_EVT_W-1:0];
            end

            // read data stands for the single cycle after the read strobe
            st_next.rd_data = PCD_REG_RST;
            if (reg_rd)
            begin
                case (reg_addr)
                    PCD_OFF_B_RISE:   st_next.rd_data = st_reg.b_rise;
                    PCD_OFF_B_FALL:   st_next.rd_data = st_reg.b_fall;
                    PCD_OFF_B_FLAGS:  st_next.rd_data = b_flags;
                    PCD_OFF_C_RISE:   st_next.rd_data = st_reg.c_rise;
                    PCD_OFF_C_FALL:   st_next.rd_data = st_reg.c_fall;
                    PCD_OFF_C_FLAGS:  st_next.rd_data = c_flags;
                    PCD_OFF_CTRL:     st_next.rd_data = {7'h00, st_reg.irq_en};
                    PCD_OFF_EVT_STAT: st_next.rd_data = {6'h00, st_reg.evt_status};
                    PCD_OFF_EVT_MASK: st_next.rd_data = {6'h00, st_reg.evt_mask};
                    default:          st_next.rd_data = PCD_REG_RST;
                endcase
            end

            // event status clears on read, but a new event in the same cycle stays
            if (reg_rd && hit(reg_addr, PCD_OFF_EVT_STAT))
                st_next.evt_status = PCD_EVT_RST;
            st_next.evt_status = st_next.evt_status | evt_raise;

            st_next.summary    = |{b_flags_next, c_flags_next};
            st_next.change_irq = st_next.summary && st_next.irq_en;
            // wake is only asked for in sleep; the flags are registered on the same edge
            st_next.wake       = st_next.change_irq && sleep_mode;
            st_next.irq        = |(st_next.evt_status & st_next.evt_mask);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign reg_rdata           = st_reg.rd_data;
    assign change_summary_flag = st_reg.summary;
    assign change_irq_request  = st_reg.change_irq;
    assign wake_request        = st_reg.wake;
    assign irq                 = st_reg.irq;

    // a pin change is seen by the flag three edges later when nothing writes meanwhile
    sequence pcd_settle;
        (clk_en && !reg_wr) [*2];
    endsequence

    sequence pcd_b4_fall;
        clk_en && !reg_wr && $fell(port_b_pin[4]) && st_reg.b_fall[4];
    endsequence

    sequence pcd_c0_rise;
        clk_en && !reg_wr && $rose(port_c_pin[0]) && st_reg.c_rise[0];
    endsequence

    sequence pcd_c0_fall;
        clk_en && !reg_wr && $fell(port_c_pin[0]) && st_reg.c_fall[0];
    endsequence

    chk_b_fall_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
        (LARGE_VARIANT != 0) && $past(clk_en, 3) && $past(clk_en, 2) && $past(clk_en) ##0 pcd_b4_fall ##1 pcd_settle
        |=> b_flags[4] && change_summary_flag)
        else $error("enabled falling edge on port b pin 4 did not set its flag");

    chk_c_rise_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(clk_en, 3) && $past(clk_en, 2) && $past(clk_en) ##0 pcd_c0_rise ##1 pcd_settle
        |=> c_flags[0] && change_summary_flag)
        else $error("enabled rising edge on port c pin 0 did not set its flag");

    chk_c_fall_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(clk_en, 3) && $past(clk_en, 2) && $past(clk_en) ##0 pcd_c0_fall ##1 pcd_settle
        |=> c_flags[0])
        else $error("enabled falling edge on port c pin 0 did not set its flag");

    chk_b_no_spurious: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && !b_flags_wr && (((b_rise_hit & st_reg.b_rise) | (b_fall_hit & st_reg.b_fall)) == 8'h00)
        |=> b_flags == $past(b_flags))
        else $error("port b flag changed without an enabled edge");

    chk_c_no_spurious: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && !c_flags_wr && (((c_rise_hit & st_reg.c_rise) | (c_fall_hit & st_reg.c_fall)) == 8'h00)
        |=> c_flags == $past(c_flags))
        else $error("port c flag changed without an enabled edge");

    chk_b_low_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        reg_rd && (hit(reg_addr, PCD_OFF_B_RISE) || hit(reg_addr, PCD_OFF_B_FALL) || hit(reg_addr, PCD_OFF_B_FLAGS))
        |=> reg_rdata[3:0] == 4'h0)
        else $error("port b low bits did not read as zero");

    chk_clear_by_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && c_flags_wr && (reg_wdata == 8'h00) && (c_set == 8'h00)
        |=> c_flags == 8'h00 ##1 (c_flags == 8'h00) || ($past(c_set) != 8'h00) || !$past(clk_en))
        else $error("port c flags were not cleared by a zero write");

    chk_summary_or: assert property (@(posedge ref_clk) disable iff (!resetn)
        change_summary_flag == |{b_flags, c_flags})
        else $error("summary flag is not the or of the pin flags");

    chk_irq_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
        change_irq_request == (change_summary_flag && st_reg.irq_en))
        else $error("change request does not follow summary and enable");

    chk_sleep_wake: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && sleep_mode && (st_next.irq_en) && (c_set != 8'h00)
        |=> wake_request && ((c_flags & $past(c_set)) == $past(c_set)))
        else $error("edge in sleep did not wake with flags updated");

    chk_variant_c_top: assert property (@(posedge ref_clk) disable iff (!resetn)
        (LARGE_VARIANT == 0) |-> (st_reg.c_rise[7:6] == 2'h0) && (st_reg.c_fall[7:6] == 2'h0) && (b_flags == 8'h00))
        else $error("bits absent in the small variant are set");

    chk_evt_irq: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && (evt_raise != 2'h0) && ((evt_raise & st_reg.evt_mask) != 2'h0) && !reg_wr |=> irq)
        else $error("unmasked event did not raise the interrupt");

    // the pipeline only sees a rise when the enable has been high since the old sample
    sequence pcd_b5_rise;
        clk_en && !reg_wr && $rose(port_b_pin[5]) && st_reg.b_rise[5];
    endsequence

    chk_b_rise_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
        (LARGE_VARIANT != 0) && $past(clk_en) ##0 pcd_b5_rise ##1 pcd_settle
        |=> b_flags[5] && change_summary_flag)
        else $error("enabled rising edge on port b pin 5 did not set its flag");

    chk_rdata_one_cycle: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(clk_en) && !$past(reg_rd) |-> reg_rdata == PCD_REG_RST)
        else $error("read data stood longer than one cycle");

    chk_freeze_state: assert property (@(posedge ref_clk) disable iff (!resetn)
        !clk_en
        |=> (st_reg == $past(st_reg)) && (b_flags == $past(b_flags)) && (c_flags == $past(c_flags)))
        else $error("state moved while the clock enable was low");

    chk_b_low_absent: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_reg.b_rise[3:0] == 4'h0) && (st_reg.b_fall[3:0] == 4'h0)
        && (b_flags[3:0] == 4'h0))
        else $error("an absent port b bit holds a one");

    chk_wake_in_sleep: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && !sleep_mode |=> !wake_request)
        else $error("wake asked for outside sleep");

    chk_wake_needs_req: assert property (@(posedge ref_clk) disable iff (!resetn)
        wake_request |-> change_irq_request)
        else $error("wake asked for without a change request");

    chk_evt_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && (evt_raise != 2'h0)
        |=> (st_reg.evt_status & $past(evt_raise)) == $past(evt_raise))
        else $error("an event was not recorded in the status");

    chk_evt_read_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && reg_rd && hit(reg_addr, PCD_OFF_EVT_STAT) && (evt_raise == 2'h0)
        |=> st_reg.evt_status == PCD_EVT_RST)
        else $error("event status did not clear on read");

    chk_evt_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && !(reg_rd && hit(reg_addr, PCD_OFF_EVT_STAT))
        |=> (st_reg.evt_status & $past(st_reg.evt_status)) == $past(st_reg.evt_status))
        else $error("event status bit dropped without a read");

    chk_irq_masked: assert property (@(posedge ref_clk) disable iff (!resetn)
        irq == |(st_reg.evt_status & st_reg.evt_mask))
        else $error("interrupt does not follow status and mask");

    chk_detect_ungated: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && (c_set != 8'h00)
        |=> (c_flags & $past(c_set)) == $past(c_set))
        else $error("an enabled port c edge did not set its flag");

    chk_write_no_set: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && b_flags_wr && (b_set == 8'h00)
        |=> (b_flags & ~$past(b_flags)) == 8'h00)
        else $error("a flag write set a port b flag");

    chk_c_fall_ignored: assert property (@(posedge ref_clk) disable iff (!resetn)
        clk_en && !c_flags_wr && !c_flags[0] && c_fall_hit[0] && !st_reg.c_fall[0]
        |=> !c_flags[0])
        else $error("falling edge on port c pin 0 set its flag with its enable clear");

    chk_variant_b_absent: assert property (@(posedge ref_clk) disable iff (!resetn)
        (LARGE_VARIANT == 0) |-> (st_reg.b_rise == 8'h00) && (st_reg.b_fall == 8'h00))
        else $error("port b enable present in the small variant");

endmodule

// >>> dv/pcd_pin_model.sv
// far-side model: external pin levels and the processor sleep indication
module pcd_pin_model
(
    input  wire logic       ref_clk,
    output logic      [7:0] port_b_pin,
    output logic      [7:0] port_c_pin,
    output logic            sleep_mode
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        port_b_pin = 8'h00;
        port_c_pin = 8'h00;
        sleep_mode = 1'b0;
    end

    // pins move just after an edge and hold as levels, so every change lasts a full cycle
    task automatic drive(input logic [7:0] b, input logic [7:0] c, input logic slp);
        @(posedge ref_clk);
        port_b_pin <= b;
        port_c_pin <= c;
        sleep_mode <= slp;
    endtask
endmodule

// >>> dv/pcd_detector_bench.sv
// register-level testbench for the pin edge change detector
module pcd_detector_bench;
    import pcd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  ref_clk;
    logic                  resetn;
    logic                  clk_en;
    logic [7:0]            port_b_pin;
    logic [7:0]            port_c_pin;
    logic                  sleep_mode;
    logic [PCD_ADDR_W-1:0] reg_addr;
    logic [PCD_DATA_W-1:0] reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [PCD_DATA_W-1:0] reg_rdata;
    logic [PCD_DATA_W-1:0] rdata_small;
    logic                  change_summary_flag;
    logic                  change_irq_request;
    logic                  wake_request;
    logic                  irq;
    int                    err_total;
    int                    comparisons;
    int                    cycles;

    pcd_pin_model u_pins (.ref_clk(ref_clk), .port_b_pin(port_b_pin), .port_c_pin(port_c_pin),
                          .sleep_mode(sleep_mode));

    pcd_detector #(.LARGE_VARIANT(1)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .port_b_pin(port_b_pin),
        .port_c_pin(port_c_pin), .sleep_mode(sleep_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .change_summary_flag(change_summary_flag),
        .change_irq_request(change_irq_request), .wake_request(wake_request), .irq(irq));

    // small pin-count build shares the bus so both can be read side by side
    pcd_detector #(.LARGE_VARIANT(0)) u_dut_small (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .port_b_pin(port_b_pin),
        .port_c_pin(port_c_pin), .sleep_mode(sleep_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_small), .change_summary_flag(),
        .change_irq_request(), .wake_request(), .irq());

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic [7:0] ds);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        d  = reg_rdata;
        ds = rdata_small;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic [7:0] ds;
        rd(a, d, ds);
        chk("reg_rdata", d, exp);
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    initial
    begin
        logic [7:0] d;
        logic [7:0] ds;
        err_total = 0;
        comparisons = 0;
        cycles = 0;
        resetn = 1'b0;
        clk_en = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int a = 0; a < 10; a++)
            rd_chk(a[3:0], PCD_REG_RST);
        for (int a = 0; a < 3; a++)
            wr(a[3:0], 8'hff);
        rd_chk(PCD_OFF_B_RISE, 8'hf0);
        rd_chk(PCD_OFF_B_FALL, 8'hf0);
        rd_chk(PCD_OFF_B_FLAGS, 8'h00);
        wr(PCD_OFF_C_RISE, 8'hff);
        wr(PCD_OFF_C_FALL, 8'hff);
        rd(PCD_OFF_C_FALL, d, ds);
        chk("c_fall", d, 8'hff);
        chk("small c_fall", ds, PCD_C_IMPL_SMALL);
        rd(PCD_OFF_B_FALL, d, ds);
        chk("small b_fall", ds, 8'h00);
        wr(4'h9, 8'hff);
        rd_chk(4'h9, 8'h00);
        wr(PCD_OFF_B_RISE, 8'h00);
        wr(PCD_OFF_B_FALL, 8'h10);
        wr(PCD_OFF_C_RISE, 8'h01);
        wr(PCD_OFF_C_FALL, 8'h00);
        // a rise on b4 with only its fall enabled must leave the flag clear
        u_pins.drive(8'h10, 8'h00, 1'b0);
        repeat (4) @(posedge ref_clk);
        rd_chk(PCD_OFF_B_FLAGS, 8'h00);
        u_pins.drive(8'h00, 8'h01, 1'b0);
        repeat (4) @(posedge ref_clk);
        rd_chk(PCD_OFF_B_FLAGS, 8'h10);
        rd_chk(PCD_OFF_C_FLAGS, 8'h01);
        chk("summary", {7'h0, change_summary_flag}, 8'h01);
        chk("irq request", {7'h0, change_irq_request}, 8'h00);
        wr(PCD_OFF_C_FLAGS, 8'h00);
        rd_chk(PCD_OFF_C_FLAGS, 8'h00);
        u_pins.drive(8'h00, 8'h00, 1'b0);
        repeat (4) @(posedge ref_clk);
        rd_chk(PCD_OFF_C_FLAGS, 8'h00);
        wr(PCD_OFF_C_FALL, 8'h02);
        u_pins.drive(8'h00, 8'h02, 1'b0);
        u_pins.drive(8'h00, 8'h00, 1'b0);
        repeat (4) @(posedge ref_clk);
        rd_chk(PCD_OFF_C_FLAGS, 8'h02);
        wr(PCD_OFF_CTRL, 8'h01);
        repeat (3) @(posedge ref_clk);
        chk("irq request", {7'h0, change_irq_request}, 8'h01);
        // the clearing write is taken on the very edge that records the new c0 rise
        u_pins.drive(8'h00, 8'h01, 1'b0);
        @(posedge ref_clk);
        wr(PCD_OFF_C_FLAGS, 8'h00);
        rd_chk(PCD_OFF_C_FLAGS, 8'h01);
        wr(PCD_OFF_C_FLAGS, 8'h00);
        wr(PCD_OFF_B_FLAGS, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk("summary", {7'h0, change_summary_flag}, 8'h00);
        chk("irq request", {7'h0, change_irq_request}, 8'h00);
        rd_chk(PCD_OFF_EVT_STAT, 8'h03);
        rd_chk(PCD_OFF_EVT_STAT, 8'h00);
        wr(PCD_OFF_EVT_MASK, 8'h02);
        chk("irq", {7'h0, irq}, 8'h00);
        u_pins.drive(8'h00, 8'h00, 1'b0);
        u_pins.drive(8'h00, 8'h01, 1'b0);
        repeat (4) @(posedge ref_clk);
        chk("irq", {7'h0, irq}, 8'h01);
        wr(PCD_OFF_EVT_MASK, 8'h00);
        repeat (2) @(posedge ref_clk);
        chk("irq", {7'h0, irq}, 8'h00);
        rd_chk(PCD_OFF_EVT_STAT, 8'h02);
        wr(PCD_OFF_C_FLAGS, 8'h00);
        u_pins.drive(8'h00, 8'h00, 1'b1);
        repeat (4) @(posedge ref_clk);
        chk("wake", {7'h0, wake_request}, 8'h00);
        u_pins.drive(8'h00, 8'h01, 1'b1);
        repeat (5) @(posedge ref_clk);
        chk("wake", {7'h0, wake_request}, 8'h01);
        rd_chk(PCD_OFF_C_FLAGS, 8'h01);
        // a write while the clock enable is low must be lost
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(PCD_OFF_B_RISE, 8'h20);
        clk_en <= 1'b1;
        rd_chk(PCD_OFF_B_RISE, 8'h00);
        wr(PCD_OFF_B_RISE, 8'h20);
        u_pins.drive(8'h20, 8'h01, 1'b0);
        repeat (4) @(posedge ref_clk);
        rd_chk(PCD_OFF_B_FLAGS, 8'h20);
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_chk(PCD_OFF_C_RISE, 8'h00);
        rd_chk(PCD_OFF_CTRL, 8'h00);
        rd_chk(PCD_OFF_C_FLAGS, 8'h00);
        chk("wake", {7'h0, wake_request}, 8'h00);
        report_and_stop();
    end
endmodule
